// File: include/mmd_defs.svh
// Constants for the memory map decoder: sizes, map limits, mode register layout.
// Assumes 16-bit addresses and 24-bit data words on every bus.
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

// ****************************************
// Sizes
// ****************************************
`define MMD_AW          16
`define MMD_DW          24
`define MMD_PRAM_WORDS  512
`define MMD_BOOT_WORDS  64
`define MMD_DRAM_WORDS  256
`define MMD_DROM_WORDS  256

// ****************************************
// Map limits
// ****************************************
`define MMD_VEC_TOP     16'h007f
`define MMD_PRAM_TOP    16'h01ff
`define MMD_DRAM_TOP    16'h00ff
`define MMD_DROM_BASE   16'h0100
`define MMD_DROM_TOP    16'h01ff
`define MMD_PERIPH_BASE 16'hffc0

// ****************************************
// Mode register layout and ROM seeds
// ****************************************
`define MMD_OMR_MA      0
`define MMD_OMR_MB      1
`define MMD_OMR_DE      2
`define MMD_OMR_YD      3
`define MMD_OMR_MC      4
`define MMD_OMR_SD      6
`define MMD_OMR_MASK    24'h00005f
`define MMD_OMR_RST     24'h000000
`define MMD_MODE_SINGLE 3'h0
`define MMD_MODE_BOOTE  3'h1
`define MMD_MODE_DEV    3'h3
`define MMD_ROM_SEED_X  24'h5a3c91
`define MMD_ROM_SEED_Y  24'h1e6b27
`define MMD_ROM_SEED_B  24'h0c0ffe

`endif

// File: include/mmd_pkg.sv
// Types shared by the memory map decoder files.
// Assumes nothing beyond the constants header.
package mmd_pkg;

  // ****************************************
  // Mode register operations
  // ****************************************
  typedef enum logic [2:0] {
    MMD_OP_MOVE = 3'b000,
    MMD_OP_AND  = 3'b001,
    MMD_OP_OR   = 3'b010,
    MMD_OP_BSET = 3'b011,
    MMD_OP_BCLR = 3'b100,
    MMD_OP_BCHG = 3'b101
  } mmd_op_t;

  // ****************************************
  // Access targets
  // ****************************************
  typedef enum logic [2:0] {
    MMD_T_NONE   = 3'b000,
    MMD_T_RAM    = 3'b001,
    MMD_T_ROM    = 3'b010,
    MMD_T_PERIPH = 3'b011,
    MMD_T_EXT    = 3'b100,
    MMD_T_BOOT   = 3'b101
  } mmd_target_t;

endpackage

// File: logic/mmd_decoder.sv
// Memory map decoder and operating mode register.
// Assumes one access per bus per cycle and inputs synchronous to clk_sys_i.
//
// Contract
// - 512 word program RAM, 64 word boot ROM
// - Vector table in lowest 128 program words
// - Unserved addresses go to external bus
// - X RAM answers X addresses 0 to 255
// - X ROM answers 256-511 when enabled
// - Peripherals decoded in top 64 X words
// - Y RAM answers Y addresses 0 to 255 while Y enabled
// - Y ROM needs ROM enable, Y enabled
// - 16-bit addresses, 24-bit words per bus
// - Mode bits steer boot ROM and program map
// - Sample mode pins when reset ends
// - Mode pins become interrupt requests afterwards
// - Mode register 24 bits, six defined
// - Register changes by reset or instructions only
// - Bits 0,1 from pins, then software
// - ROM enable maps ROMs, else external
// - Reset clears ROM enable
// - Y disable makes all Y external
// - Y enabled follows ROM enable for ROM
// - Y contents kept; reset clears disable
// - Bit 4 from third pin, then software
// - Reserved bits read as zero
// - DE/YD combinations map as tabulated
`timescale 1ns/1ps
`include "mmd_defs.svh"

module mmd_decoder #(
  parameter int AW = `MMD_AW,
  parameter int DW = `MMD_DW
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rstn_i,
  // Mode pins
  input  wire logic                 mode_pin_one_i,
  input  wire logic                 mode_pin_two_i,
  input  wire logic                 mode_pin_three_i,
  output logic                      external_request_one_o,
  output logic                      external_request_two_o,
  output logic                      nmi_request_o,
  // Mode register access
  input  wire logic                 omr_wr_i,
  input  wire mmd_pkg::mmd_op_t     omr_op_i,
  input  wire logic [DW-1:0]        omr_wdata_i,
  input  wire logic [4:0]           omr_bit_i,
  output logic      [DW-1:0]        omr_rdata_o,
  output logic                      in_reset_o,
  // Program bus
  input  wire logic [AW-1:0]        program_address_bus_i,
  input  wire logic                 p_rd_i,
  input  wire logic                 p_wr_i,
  input  wire logic [DW-1:0]        p_wdata_i,
  input  wire logic [DW-1:0]        p_ext_rdata_i,
  output mmd_pkg::mmd_target_t      p_target_o,
  output logic                      p_ext_o,
  output logic                      p_vector_o,
  output logic      [DW-1:0]        p_rdata_o,
  // X bus
  input  wire logic [AW-1:0]        x_address_bus_i,
  input  wire logic                 x_rd_i,
  input  wire logic                 x_wr_i,
  input  wire logic [DW-1:0]        x_data_bus_i,
  input  wire logic [DW-1:0]        x_ext_rdata_i,
  input  wire logic [DW-1:0]        x_periph_rdata_i,
  output mmd_pkg::mmd_target_t      x_target_o,
  output logic                      x_ext_o,
  output logic                      x_periph_sel_o,
  output logic      [DW-1:0]        x_data_bus_o,
  // Y bus
  input  wire logic [AW-1:0]        y_address_bus_i,
  input  wire logic                 y_rd_i,
  input  wire logic                 y_wr_i,
  input  wire logic [DW-1:0]        y_data_bus_i,
  input  wire logic [DW-1:0]        y_ext_rdata_i,
  output mmd_pkg::mmd_target_t      y_target_o,
  output logic                      y_ext_o,
  output logic      [DW-1:0]        y_data_bus_o,
  // Mode outputs
  output logic                      boot_active_o,
  output logic                      stop_delay_o
);

  // ****************************************
  // Mode register
  // ****************************************
  logic [DW-1:0]        omr_r;
  logic [DW-1:0]        omr_nxt;
  logic                 in_reset_r;
  logic [2:0]           mode;
  logic                 boot_mode;
  logic                 dev_mode;
  logic                 rom_en;
  logic                 y_dis;
  logic [DW-1:0]        bit_mask;

  assign mode      = {omr_r[`MMD_OMR_MC], omr_r[`MMD_OMR_MB], omr_r[`MMD_OMR_MA]};
  assign dev_mode  = (mode == `MMD_MODE_DEV);
  // Modes 1 and 4..7 run from the boot ROM
  assign boot_mode = (mode == `MMD_MODE_BOOTE) || omr_r[`MMD_OMR_MC];
  assign rom_en    = omr_r[`MMD_OMR_DE];
  assign y_dis     = omr_r[`MMD_OMR_YD];
  assign bit_mask  = DW'(1) << omr_bit_i;

  always_comb begin
    unique case (omr_op_i)
      mmd_pkg::MMD_OP_MOVE: omr_nxt = omr_wdata_i;
      mmd_pkg::MMD_OP_AND:  omr_nxt = omr_r & omr_wdata_i;
      mmd_pkg::MMD_OP_OR:   omr_nxt = omr_r | omr_wdata_i;
      mmd_pkg::MMD_OP_BSET: omr_nxt = omr_r | bit_mask;
      mmd_pkg::MMD_OP_BCLR: omr_nxt = omr_r & ~bit_mask;
      mmd_pkg::MMD_OP_BCHG: omr_nxt = omr_r ^ bit_mask;
      default:              omr_nxt = omr_r;
    endcase
  end

  // Flag marks the first edge after release, where pins are caught
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_reset_r <= 1'b1;
    end else begin
      in_reset_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      omr_r <= `MMD_OMR_RST;
    end else if (in_reset_r) begin
      omr_r                <= `MMD_OMR_RST;
      omr_r[`MMD_OMR_MA]   <= mode_pin_one_i;
      omr_r[`MMD_OMR_MB]   <= mode_pin_two_i;
      omr_r[`MMD_OMR_MC]   <= mode_pin_three_i;
    end else if (omr_wr_i) begin
      // Only defined bits are kept
      omr_r <= omr_nxt & `MMD_OMR_MASK;
    end
  end

  assign omr_rdata_o   = omr_r;
  assign in_reset_o    = in_reset_r;
  assign boot_active_o = boot_mode;
  assign stop_delay_o  = omr_r[`MMD_OMR_SD];

  // ****************************************
  // Pin reuse after reset
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      external_request_one_o <= 1'b0;
      external_request_two_o <= 1'b0;
      nmi_request_o          <= 1'b0;
    end else begin
      external_request_one_o <= mode_pin_one_i & ~in_reset_r;
      external_request_two_o <= mode_pin_two_i & ~in_reset_r;
      nmi_request_o          <= mode_pin_three_i & ~in_reset_r;
    end
  end

  // ****************************************
  // Program space decode
  // ****************************************
  mmd_pkg::mmd_target_t p_tgt;

  always_comb begin
    p_tgt = mmd_pkg::MMD_T_NONE;
    if (p_rd_i || p_wr_i) begin
      if (!dev_mode && program_address_bus_i <= `MMD_PRAM_TOP) begin
        // Boot reads come from ROM, writes still load RAM
        if (boot_mode && p_rd_i) begin
          p_tgt = mmd_pkg::MMD_T_BOOT;
        end else begin
          p_tgt = mmd_pkg::MMD_T_RAM;
        end
      end else begin
        p_tgt = mmd_pkg::MMD_T_EXT;
      end
    end
  end

  assign p_target_o = p_tgt;
  assign p_ext_o    = (p_tgt == mmd_pkg::MMD_T_EXT);
  assign p_vector_o = (p_tgt != mmd_pkg::MMD_T_NONE) && (program_address_bus_i <= `MMD_VEC_TOP);

  // ****************************************
  // X space decode
  // ****************************************
  mmd_pkg::mmd_target_t x_tgt;

  always_comb begin
    x_tgt = mmd_pkg::MMD_T_NONE;
    if (x_rd_i || x_wr_i) begin
      if (x_address_bus_i <= `MMD_DRAM_TOP) begin
        x_tgt = mmd_pkg::MMD_T_RAM;
      end else if (rom_en && x_address_bus_i <= `MMD_DROM_TOP) begin
        x_tgt = mmd_pkg::MMD_T_ROM;
      end else if (x_address_bus_i >= `MMD_PERIPH_BASE) begin
        x_tgt = mmd_pkg::MMD_T_PERIPH;
      end else begin
        x_tgt = mmd_pkg::MMD_T_EXT;
      end
    end
  end

  assign x_target_o     = x_tgt;
  assign x_ext_o        = (x_tgt == mmd_pkg::MMD_T_EXT);
  assign x_periph_sel_o = (x_tgt == mmd_pkg::MMD_T_PERIPH);

  // ****************************************
  // Y space decode
  // ****************************************
  mmd_pkg::mmd_target_t y_tgt;

  always_comb begin
    y_tgt = mmd_pkg::MMD_T_NONE;
    if (y_rd_i || y_wr_i) begin
      if (y_dis) begin
        y_tgt = mmd_pkg::MMD_T_EXT;
      end else if (y_address_bus_i <= `MMD_DRAM_TOP) begin
        y_tgt = mmd_pkg::MMD_T_RAM;
      end else if (rom_en && y_address_bus_i <= `MMD_DROM_TOP) begin
        y_tgt = mmd_pkg::MMD_T_ROM;
      end else begin
        // Top 64 Y words go off chip for outside peripherals
        y_tgt = mmd_pkg::MMD_T_EXT;
      end
    end
  end

  assign y_target_o = y_tgt;
  assign y_ext_o    = (y_tgt == mmd_pkg::MMD_T_EXT);

  // ****************************************
  // Internal memories
  // ****************************************
  logic [DW-1:0] pram_q;
  logic [DW-1:0] boot_q;
  logic [DW-1:0] xram_q;
  logic [DW-1:0] xrom_q;
  logic [DW-1:0] yram_q;
  logic [DW-1:0] yrom_q;
  logic          pram_we;
  logic          xram_we;
  logic          yram_we;

  // ROM targets ignore writes
  assign pram_we = p_wr_i && (p_tgt == mmd_pkg::MMD_T_RAM);
  assign xram_we = x_wr_i && (x_tgt == mmd_pkg::MMD_T_RAM);
  // Y RAM untouched while disabled, so its contents stay
  assign yram_we = y_wr_i && (y_tgt == mmd_pkg::MMD_T_RAM);

  mmd_ram #(
    .WORDS (`MMD_PRAM_WORDS),
    .AW    (9),
    .DW    (DW)
  ) u_pram (
    .clk_sys_i (clk_sys_i),
    .we_i      (pram_we),
    .addr_i    (program_address_bus_i[8:0]),
    .wdata_i   (p_wdata_i),
    .rdata_o   (pram_q)
  );

  mmd_rom #(
    .AW   (6),
    .DW   (DW),
    .SEED (`MMD_ROM_SEED_B)
  ) u_boot (
    .addr_i  (program_address_bus_i[5:0]),
    .rdata_o (boot_q)
  );

  mmd_ram #(
    .WORDS (`MMD_DRAM_WORDS),
    .AW    (8),
    .DW    (DW)
  ) u_xram (
    .clk_sys_i (clk_sys_i),
    .we_i      (xram_we),
    .addr_i    (x_address_bus_i[7:0]),
    .wdata_i   (x_data_bus_i),
    .rdata_o   (xram_q)
  );

  mmd_rom #(
    .AW   (8),
    .DW   (DW),
    .SEED (`MMD_ROM_SEED_X)
  ) u_xrom (
    .addr_i  (x_address_bus_i[7:0]),
    .rdata_o (xrom_q)
  );

  mmd_ram #(
    .WORDS (`MMD_DRAM_WORDS),
    .AW    (8),
    .DW    (DW)
  ) u_yram (
    .clk_sys_i (clk_sys_i),
    .we_i      (yram_we),
    .addr_i    (y_address_bus_i[7:0]),
    .wdata_i   (y_data_bus_i),
    .rdata_o   (yram_q)
  );

  mmd_rom #(
    .AW   (8),
    .DW   (DW),
    .SEED (`MMD_ROM_SEED_Y)
  ) u_yrom (
    .addr_i  (y_address_bus_i[7:0]),
    .rdata_o (yrom_q)
  );

  // ****************************************
  // Read data return
  // ****************************************
  // One cycle late, from flip-flops, so the map may change underneath
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p_rdata_o <= '0;
    end else if (p_rd_i) begin
      unique case (p_tgt)
        mmd_pkg::MMD_T_RAM:  p_rdata_o <= pram_q;
        mmd_pkg::MMD_T_BOOT: p_rdata_o <= boot_q;
        default:             p_rdata_o <= p_ext_rdata_i;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      x_data_bus_o <= '0;
    end else if (x_rd_i) begin
      unique case (x_tgt)
        mmd_pkg::MMD_T_RAM:    x_data_bus_o <= xram_q;
        mmd_pkg::MMD_T_ROM:    x_data_bus_o <= xrom_q;
        mmd_pkg::MMD_T_PERIPH: x_data_bus_o <= x_periph_rdata_i;
        default:               x_data_bus_o <= x_ext_rdata_i;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      y_data_bus_o <= '0;
    end else if (y_rd_i) begin
      unique case (y_tgt)
        mmd_pkg::MMD_T_RAM: y_data_bus_o <= yram_q;
        mmd_pkg::MMD_T_ROM: y_data_bus_o <= yrom_q;
        default:            y_data_bus_o <= y_ext_rdata_i;
      endcase
    end
  end

endmodule

// File: logic/mmd_ram.sv
// Internal single-port RAM with synchronous write and direct read.
// Assumes the decoder gates the write strobe by the current map.
`timescale 1ns/1ps

module mmd_ram #(
  parameter int WORDS = 256,
  parameter int AW    = 8,
  parameter int DW    = 24
) (
  input  wire logic          clk_sys_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  // ****************************************
  // Storage
  // ****************************************
  // No reset: contents survive map changes
  logic [DW-1:0] mem [WORDS];

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[addr_i];

endmodule

// File: logic/mmd_rom.sv
// Factory-programmed ROM model: fixed contents derived from the address.
// Assumes the seed stands in for the real mask contents.
`timescale 1ns/1ps

module mmd_rom #(
  parameter int          AW   = 8,
  parameter int          DW   = 24,
  parameter logic [23:0] SEED = 24'h000001
) (
  input  wire logic [AW-1:0] addr_i,
  output logic      [DW-1:0] rdata_o
);

  // ****************************************
  // Contents
  // ****************************************
  logic [23:0] word;

  always_comb begin
    // Narrow boot address is zero-extended to a byte
    word    = {3{8'(addr_i)}} ^ SEED;
    rdata_o = word[DW-1:0];
  end

endmodule

// File: tb/mmd_dec_checker.sv
// Checker for the decoder: map, mode register, mode pins.
// Assumes binding to the decoder ports by name.
`timescale 1ns/1ps

module mmd_dec_checker (
  input wire logic                 clk_sys_i,
  input wire logic                 rstn_i,
  input wire logic                 mode_pin_one_i,
  input wire logic                 mode_pin_two_i,
  input wire logic                 mode_pin_three_i,
  input wire logic                 external_request_one_o,
  input wire logic                 external_request_two_o,
  input wire logic                 nmi_request_o,
  input wire logic                 omr_wr_i,
  input wire mmd_pkg::mmd_op_t     omr_op_i,
  input wire logic [23:0]          omr_wdata_i,
  input wire logic [23:0]          omr_rdata_o,
  input wire logic                 in_reset_o,
  input wire logic [15:0]          program_address_bus_i,
  input wire logic                 p_rd_i,
  input wire logic                 p_vector_o,
  input wire logic [15:0]          x_address_bus_i,
  input wire logic                 x_rd_i,
  input wire mmd_pkg::mmd_target_t x_target_o,
  input wire logic                 x_periph_sel_o,
  input wire logic                 y_rd_i,
  input wire logic                 y_wr_i,
  input wire mmd_pkg::mmd_target_t y_target_o,
  input wire logic                 y_ext_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // ****
  // Sequences
  // ****
  sequence s_rst_exit;
    in_reset_o ##1 !in_reset_o;
  endsequence
  sequence s_xrom;
    x_rd_i && x_address_bus_i[15:8] == 8'h01;
  endsequence

  // ****
  // Assertions
  // ****
  a_load_pins: assert property (s_rst_exit |-> omr_rdata_o ==
    {19'h0, $past(mode_pin_three_i), 2'b0, $past(mode_pin_two_i), $past(mode_pin_one_i)})
    else $error("pins not loaded");
  a_pins_irq: assert property (!in_reset_o && !$past(in_reset_o) |->
    {nmi_request_o, external_request_two_o, external_request_one_o} ==
    {$past(mode_pin_three_i), $past(mode_pin_two_i), $past(mode_pin_one_i)}) else $error("request not pin");
  a_resv_zero: assert property ((omr_rdata_o & 24'hffffa0) == 24'h0)
    else $error("reserved bit set");
  a_omr_move: assert property (omr_wr_i && !in_reset_o && omr_op_i == mmd_pkg::MMD_OP_MOVE |=>
    omr_rdata_o == ($past(omr_wdata_i) & 24'h00005f)) else $error("move not applied");
  a_omr_hold: assert property (!omr_wr_i && !in_reset_o |=> $stable(omr_rdata_o))
    else $error("mode register changed");
  a_x_ram: assert property (x_rd_i && x_address_bus_i < 16'h0100 |-> x_target_o == mmd_pkg::MMD_T_RAM)
    else $error("x ram miss");
  a_x_rom: assert property (s_xrom |-> x_target_o ==
    (omr_rdata_o[2] ? mmd_pkg::MMD_T_ROM : mmd_pkg::MMD_T_EXT)) else $error("x rom range wrong");
  a_x_periph: assert property (x_rd_i && x_address_bus_i > 16'hffbf |->
    x_target_o == mmd_pkg::MMD_T_PERIPH && x_periph_sel_o) else $error("periph miss");
  a_y_off: assert property ((y_rd_i || y_wr_i) && omr_rdata_o[3] |->
    y_target_o == mmd_pkg::MMD_T_EXT && y_ext_o) else $error("y not external");
  a_p_vec: assert property (p_rd_i && program_address_bus_i < 16'h0080 |-> p_vector_o)
    else $error("vector miss");
endmodule

bind mmd_decoder mmd_dec_checker u_mmd_chk (.*);

// File: tb/mmd_far_mem.sv
// Far side model: external memory and peripherals behind the decoder.
// Assumes combinational reads from the current address.
`timescale 1ns/1ps

module mmd_far_mem (
  input  wire logic [15:0] p_addr_i,
  input  wire logic [15:0] x_addr_i,
  input  wire logic [15:0] y_addr_i,
  input  wire logic        p_sel_i,
  input  wire logic        x_sel_i,
  input  wire logic        per_sel_i,
  input  wire logic        y_sel_i,
  output logic      [23:0] p_data_o,
  output logic      [23:0] x_data_o,
  output logic      [23:0] per_data_o,
  output logic      [23:0] y_data_o
);
  // Inverted word when not selected, so a misrouted read never matches
  assign p_data_o   = {8'h11, p_addr_i} ^ {24{!p_sel_i}};
  assign x_data_o   = {8'h22, x_addr_i} ^ {24{!x_sel_i}};
  assign per_data_o = {8'h44, x_addr_i} ^ {24{!per_sel_i}};
  assign y_data_o   = {(y_addr_i > 16'hffbf) ? 8'h55 : 8'h33, y_addr_i} ^ {24{!y_sel_i}};
endmodule

// File: tb/testbench.sv
// Self-checking bench for the memory map decoder.
// Assumes the far side model and the checker bind.
`timescale 1ns/1ps
`include "mmd_defs.svh"

module testbench;
  // ****
  // State
  // ****
  localparam logic [15:0] AL [10] = '{16'h0000, 16'h007f, 16'h0080, 16'h00ff, 16'h0100,
                                      16'h01ff, 16'h0200, 16'hffbf, 16'hffc0, 16'hffff};
  localparam logic [23:0] MD [4] = '{24'h1, 24'h3, 24'h10, 24'h0};
  logic                 clk_sys_i, rstn_i, omr_wr, inr, per, ba, sd;
  logic [2:0]           pins, req;
  mmd_pkg::mmd_op_t     op;
  logic [23:0]          owd, ord, om, pd;
  logic [4:0]           obit;
  logic [15:0]          ad [3];
  logic                 rd [3], wr [3], ex [3];
  logic [23:0]          wd [3], ed [3], dt [3];
  mmd_pkg::mmd_target_t tg [3];
  logic [23:0]          mem [3][512];
  logic [23:0]          q [$];
  int                   failures, comparisons, pend;

  mmd_decoder dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .mode_pin_one_i(pins[0]), .mode_pin_two_i(pins[1]),
    .mode_pin_three_i(pins[2]), .external_request_one_o(req[0]), .external_request_two_o(req[1]),
    .nmi_request_o(req[2]), .omr_wr_i(omr_wr), .omr_op_i(op), .omr_wdata_i(owd), .omr_bit_i(obit),
    .omr_rdata_o(ord), .in_reset_o(inr), .program_address_bus_i(ad[0]), .p_rd_i(rd[0]), .p_wr_i(wr[0]),
    .p_wdata_i(wd[0]), .p_ext_rdata_i(ed[0]), .p_target_o(tg[0]), .p_ext_o(ex[0]), .p_vector_o(),
    .p_rdata_o(dt[0]), .x_address_bus_i(ad[1]), .x_rd_i(rd[1]), .x_wr_i(wr[1]), .x_data_bus_i(wd[1]),
    .x_ext_rdata_i(ed[1]), .x_periph_rdata_i(pd), .x_target_o(tg[1]), .x_ext_o(ex[1]),
    .x_periph_sel_o(per), .x_data_bus_o(dt[1]), .y_address_bus_i(ad[2]), .y_rd_i(rd[2]), .y_wr_i(wr[2]),
    .y_data_bus_i(wd[2]), .y_ext_rdata_i(ed[2]), .y_target_o(tg[2]), .y_ext_o(ex[2]),
    .y_data_bus_o(dt[2]), .boot_active_o(ba), .stop_delay_o(sd));

  mmd_far_mem far (.p_addr_i(ad[0]), .x_addr_i(ad[1]), .y_addr_i(ad[2]), .p_sel_i(ex[0]), .x_sel_i(ex[1]),
    .per_sel_i(per), .y_sel_i(ex[2]), .p_data_o(ed[0]), .x_data_o(ed[1]), .per_data_o(pd), .y_data_o(ed[2]));

  always #10 clk_sys_i = ~clk_sys_i;

  // ****
  // Checks and expectations
  // ****
  task automatic chk_t(string n, mmd_pkg::mmd_target_t e, mmd_pkg::mmd_target_t g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic chk_d(string n, logic [23:0] e, logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic mmd_pkg::mmd_target_t tgt(int b, bit w, logic [15:0] a);
    if (b == 0) begin
      if ((!om[4] && om[1:0] == 2'h3) || a > 16'h01ff) return mmd_pkg::MMD_T_EXT;
      return (!w && (om[4] || om[1:0] == 2'h1)) ? mmd_pkg::MMD_T_BOOT : mmd_pkg::MMD_T_RAM;
    end
    if ((b == 2 && om[3]) || a > 16'h01ff)
      return (b == 1 && a > 16'hffbf) ? mmd_pkg::MMD_T_PERIPH : mmd_pkg::MMD_T_EXT;
    if (a < 16'h0100) return mmd_pkg::MMD_T_RAM;
    return om[2] ? mmd_pkg::MMD_T_ROM : mmd_pkg::MMD_T_EXT;
  endfunction

  function automatic logic [23:0] dat(int b, logic [15:0] a, mmd_pkg::mmd_target_t t);
    case (t)
      mmd_pkg::MMD_T_RAM:    return mem[b][a[8:0]];
      mmd_pkg::MMD_T_ROM:    return {3{a[7:0]}} ^ (b == 1 ? `MMD_ROM_SEED_X : `MMD_ROM_SEED_Y);
      mmd_pkg::MMD_T_BOOT:   return {3{2'h0, a[5:0]}} ^ `MMD_ROM_SEED_B;
      mmd_pkg::MMD_T_PERIPH: return {8'h44, a};
      default:               return {b == 0 ? 8'h11 : b == 1 ? 8'h22 : a > 16'hffbf ? 8'h55 : 8'h33, a};
    endcase
  endfunction

  // ****
  // Drivers
  // ****
  task automatic acc(int b, bit w, logic [15:0] a);
    mmd_pkg::mmd_target_t e;
    logic [23:0]          d;
    d = $urandom;
    e = tgt(b, w, a);
    @(posedge clk_sys_i);
    #1;
    for (int i = 0; i < 3; i++) begin
      rd[i] = (i == b) && !w;
      wr[i] = (i == b) && w;
    end
    ad[b] = a;
    wd[b] = d;
    #5;
    chk_t("target", e, tg[b]);
    if (w && e == mmd_pkg::MMD_T_RAM) mem[b][a[8:0]] = d;
    if (!w) q.push_back(dat(b, a, e));
  endtask

  task automatic om_op(mmd_pkg::mmd_op_t o, logic [23:0] d, logic [4:0] bi);
    logic [23:0] m;
    m = 24'h1 << bi;
    case (o)
      mmd_pkg::MMD_OP_MOVE: om = d;
      mmd_pkg::MMD_OP_AND:  om = om & d;
      mmd_pkg::MMD_OP_OR:   om = om | d;
      mmd_pkg::MMD_OP_BSET: om = om | m;
      mmd_pkg::MMD_OP_BCLR: om = om & ~m;
      default:              om = om ^ m;
    endcase
    om = om & `MMD_OMR_MASK;
    @(posedge clk_sys_i);
    #1;
    for (int i = 0; i < 3; i++) begin
      rd[i] = 0;
      wr[i] = 0;
    end
    omr_wr = 1;
    op = o;
    owd = d;
    obit = bi;
    @(posedge clk_sys_i);
    #1;
    omr_wr = 0;
    chk_d("mode register", om, ord);
    chk_d("mode outputs", {22'h0, (om[4] || om[1:0] == 2'h1), om[6]}, {22'h0, ba, sd});
  endtask

  task automatic rst();
    @(posedge clk_sys_i);
    #1;
    rstn_i = 0;
    repeat (16) @(posedge clk_sys_i);
    #1;
    rstn_i = 1;
    @(posedge clk_sys_i);
    #1;
    om = {19'h0, pins[2], 2'b0, pins[1], pins[0]};
    chk_d("mode register", om, ord);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys_i);
      #1;
      chk_d("requests", {21'h0, pins}, {21'h0, req});
      pins = 3'($urandom);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Read data lands one edge after the read, so it is checked a cycle later
  always @(negedge clk_sys_i) begin
    if (pend < 3) begin
      if (q.size() == 0) chk_d("read note", 24'h0, 24'hffffff);
      else chk_d("read data", q.pop_front(), dt[pend]);
    end
    pend = 3;
    for (int b = 0; b < 3; b++) if (rd[b]) pend = b;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    complete_run();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    clk_sys_i = 0;
    rstn_i = 0;
    omr_wr = 0;
    op = mmd_pkg::MMD_OP_MOVE;
    owd = 0;
    obit = 0;
    for (int b = 0; b < 3; b++) begin
      ad[b] = 0;
      rd[b] = 0;
      wr[b] = 0;
      wd[b] = 0;
    end
    failures = 0;
    comparisons = 0;
    pend = 3;
    void'($urandom(32'h458a));
    pins = 3'($urandom);
    rst();
    $display("test reset done");
    om_op(mmd_pkg::MMD_OP_MOVE, 24'hffffff, 5'h0);
    for (int k = 0; k < 12; k++) om_op(mmd_pkg::mmd_op_t'(k % 6), $urandom, 5'($urandom_range(8)));
    $display("test register done");
    for (int c = 0; c < 5; c++) begin
      om_op(mmd_pkg::MMD_OP_MOVE, 24'(c % 4) << 2, 5'h0);
      foreach (AL[i]) for (int b = 0; b < 3; b++) begin
        if (c > 0) acc(b, 0, AL[i]);
        acc(b, 1, AL[i]);
        acc(b, 0, AL[i]);
      end
    end
    $display("test map done");
    foreach (MD[i]) begin
      om_op(mmd_pkg::MMD_OP_MOVE, MD[i], 5'h0);
      acc(0, 0, 16'h0005);
      acc(0, 1, 16'h0005);
      acc(0, 0, 16'h01ff);
    end
    $display("test program map done");
    om_op(mmd_pkg::MMD_OP_MOVE, 24'h4c, 5'h0);
    rst();
    $display("test second reset done");
    repeat (2) @(posedge clk_sys_i);
    chk_d("notes left", 24'h0, 24'(q.size()));
    complete_run();
  end
endmodule
